// >>> design/adc_pkg.sv
// Shared constants of the converter control block: register map, field
// positions, reset values and conversion timing.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
package adc_pkg;

    // =====================================================================
    // Register map (byte addresses, one aligned word each)
    // =====================================================================
    localparam logic [4:0] CONTROL_OFS   = 5'h00;  // converter_control_reg
    localparam logic [4:0] RESULT_OFS    = 5'h04;  // conversion_result_reg
    localparam logic [4:0] PORTCFG_OFS   = 5'h08;  // port_analog_config_reg
    localparam logic [4:0] IRQ_STAT_OFS  = 5'h0c;  // Sticky event status, read only
    localparam logic [4:0] IRQ_CLR_OFS   = 5'h10;  // Write one to clear, write only
    localparam logic [4:0] IRQ_EN_OFS    = 5'h14;  // Interrupt enable

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int CLKSEL_LSB = 6;   // conv_clock_select[7:6]
    localparam int CHAN_LSB   = 3;   // channel_select[5:3]
    localparam int GO_BIT     = 2;   // Go/done
    localparam int POWER_BIT  = 0;   // converter_power_on
    localparam int REFCFG_BIT = 0;   // reference_config: 1 = external reference pin
    localparam int DONE_EVT   = 0;   // Conversion complete event

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] RESULT_RST  = 8'h00;
    localparam logic [7:0] PORTCFG_RST = 8'h00;
    localparam logic [0:0] IRQ_RST     = 1'h0;

    // =====================================================================
    // Encodings
    // =====================================================================
    localparam logic [1:0] CLK_DIV2  = 2'h0;
    localparam logic [1:0] CLK_DIV8  = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_RC    = 2'h3;
    localparam logic [2:0] CHAN_LAST = 3'h3;   // Highest legal input

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_PERIOD_NS  = 100;
    localparam int RC_PERIOD_NS   = 4000;      // Typical dedicated RC bit period
    localparam int RC_HALF_CYCLES = (RC_PERIOD_NS / CLK_PERIOD_NS) / 2;
    localparam int HALF_DIV2      = 1;         // Half bit period, in system clocks
    localparam int HALF_DIV8      = 4;
    localparam int HALF_DIV32     = 16;
    localparam int CONV_HALVES    = 19;        // 9.5 bit periods
    localparam int RESULT_BITS    = 8;

endpackage

// >>> design/conv_clock_gen.sv
// Conversion clock generator: one-cycle half bit period strobes.
// Assumes the single system clock; the RC source is modelled as a fixed
// count of that clock, so no second clock domain exists.
`timescale 1ns/1ps
module conv_clock_gen #(
    parameter int RC_HALF = adc_pkg::RC_HALF_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_run,
    input  wire logic [1:0] i_sel,
    output logic            o_half_tick
);

    // =====================================================================
    // Divider
    // =====================================================================
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [4:0] half_len;

    // Half bit length for the chosen source; divided sources track i_clk
    always_comb begin
        case (i_sel)
            adc_pkg::CLK_DIV2:  half_len = 5'(adc_pkg::HALF_DIV2);
            adc_pkg::CLK_DIV8:  half_len = 5'(adc_pkg::HALF_DIV8);
            adc_pkg::CLK_DIV32: half_len = 5'(adc_pkg::HALF_DIV32);
            default:            half_len = 5'(RC_HALF);
        endcase
    end

    // Counter restarts whenever the sequencer is idle
    always_comb begin
        o_half_tick = i_run && (cnt_reg == half_len - 5'h01);
        if (!i_run || o_half_tick) begin
            cnt_next = 5'h00;
        end else begin
            cnt_next = cnt_reg + 5'h01;
        end
    end

    // Register the count
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg <= 5'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule

// >>> design/sar_adc_control.sv
// Control logic of an 8-bit successive approximation converter.
// Assumes an Avalon-MM master on the register side and an analog mux,
// sample-and-hold, reference DAC and comparator on the pin side.
//
// Summary of operation
// - Result is eight bits, resolved one bit per step by successive approximation.
// - Final conversion value is written into the readable result register.
// - All inputs share one sample-and-hold through a mux, feeding the converter.
// - Channel select field chooses which input reaches the sample-and-hold.
// - Positive reference is selectable between supply and external reference pin.
// - Conversion clock is system clock over 2, 8, 32, or dedicated RC.
// - One bit period equals one period of the selected conversion clock.
// - A full conversion lasts nine and a half bit periods.
// - Divided sources follow the system clock, so its rate sets bit period.
// - Completion raises an interrupt request that can wake the device when the RC clock is selected.
// - Software sets go/done to start; hardware holds it, clears on completion.
// - Power-on bit enables the converter; clear means disabled, no current.
// - Clock field codes 00, 01, 10, 11 mean /2, /8, /32, RC.
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module sar_adc_control #(
    parameter int RC_HALF = adc_pkg::RC_HALF_CYCLES
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [4:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_comp_above,
    output logic [7:0]       o_dac_code,
    output logic [1:0]       o_mux_select,
    output logic             o_mux_enable,
    output logic             o_hold,
    output logic             o_ref_external,
    output logic             o_converter_power,
    output logic             o_irq,
    output logic             o_wake
);

    // =====================================================================
    // Bus slave: one wait cycle, then the request is taken
    // =====================================================================
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        wr_fire;

    // Wait request drops one cycle after a request appears
    always_comb begin
        o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_reg;
        wr_fire           = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
        ack_next          = (i_avs_read || i_avs_write) && !ack_reg;
    end

    // =====================================================================
    // Registers
    // =====================================================================
    logic [7:0] converter_control_reg;
    logic [7:0] converter_control_next;
    logic [7:0] conversion_result_reg;
    logic [7:0] conversion_result_next;
    logic [7:0] port_analog_config_reg;
    logic [7:0] port_analog_config_next;
    logic [0:0] irq_status_reg;
    logic [0:0] irq_status_next;
    logic [0:0] irq_enable_reg;
    logic [0:0] irq_enable_next;
    logic [1:0] clk_sel_reg;
    logic [1:0] clk_sel_next;
    logic [4:0] tick_cnt_reg;
    logic [4:0] tick_cnt_next;

    logic [7:0] wbyte;
    logic       go_reg;
    logic       power_reg;
    logic       start;
    logic       abort;
    logic       half_tick;
    logic       step;
    logic       conv_done;
    logic [7:0] sar_code;

    assign wbyte     = i_avs_writedata[7:0];
    assign go_reg    = converter_control_reg[adc_pkg::GO_BIT];
    assign power_reg = converter_control_reg[adc_pkg::POWER_BIT];

    // Start needs the go bit and the power bit in the same write, while idle
    always_comb begin
        start = wr_fire && i_avs_address == adc_pkg::CONTROL_OFS && !go_reg
             && wbyte[adc_pkg::GO_BIT] && wbyte[adc_pkg::POWER_BIT];
        abort = wr_fire && i_avs_address == adc_pkg::CONTROL_OFS && go_reg
             && !wbyte[adc_pkg::POWER_BIT];
    end

    // Sequencer: nineteen half bit strobes, bits resolved on full periods
    always_comb begin
        step      = go_reg && half_tick && tick_cnt_reg[0] && tick_cnt_reg >= 5'h03;
        conv_done = go_reg && half_tick
                 && tick_cnt_reg == 5'(adc_pkg::CONV_HALVES - 1);
        if (!go_reg || abort || conv_done) begin
            tick_cnt_next = 5'h00;
        end else if (half_tick) begin
            tick_cnt_next = tick_cnt_reg + 5'h01;
        end else begin
            tick_cnt_next = tick_cnt_reg;
        end
    end

    // Control register: software fields, go/done owned by hardware when busy
    always_comb begin
        converter_control_next = converter_control_reg;
        clk_sel_next           = clk_sel_reg;
        if (wr_fire && i_avs_address == adc_pkg::CONTROL_OFS) begin
            converter_control_next = wbyte & 8'hfd;          // Bit 1 reads zero
            converter_control_next[adc_pkg::GO_BIT] = go_reg || start;
            if (go_reg) begin
                // Source and channel stay fixed during a conversion
                converter_control_next[7:3] = converter_control_reg[7:3];
            end
        end
        if (start) begin
            clk_sel_next = wbyte[adc_pkg::CLKSEL_LSB +: 2];
        end
        if (conv_done || !converter_control_next[adc_pkg::POWER_BIT]) begin
            converter_control_next[adc_pkg::GO_BIT] = 1'b0;
        end
    end

    // Result, reference config and interrupt registers
    always_comb begin
        conversion_result_next  = conversion_result_reg;
        port_analog_config_next = port_analog_config_reg;
        irq_enable_next         = irq_enable_reg;
        irq_status_next         = irq_status_reg;
        if (conv_done) begin
            conversion_result_next = sar_code;
        end
        if (wr_fire && i_avs_address == adc_pkg::PORTCFG_OFS) begin
            port_analog_config_next = {7'h00, wbyte[adc_pkg::REFCFG_BIT]};
        end
        if (wr_fire && i_avs_address == adc_pkg::IRQ_EN_OFS) begin
            irq_enable_next = wbyte[0:0];
        end
        if (wr_fire && i_avs_address == adc_pkg::IRQ_CLR_OFS) begin
            irq_status_next = irq_status_reg & ~wbyte[0:0];
        end
        if (conv_done) begin
            irq_status_next[adc_pkg::DONE_EVT] = 1'b1;
        end
    end

    // Read mux; unmapped and write-only words read zero
    always_comb begin
        rdata_next = rdata_reg;
        if (i_avs_read && !ack_reg) begin
            case (i_avs_address)
                adc_pkg::CONTROL_OFS:  rdata_next = {24'h000000, converter_control_reg};
                adc_pkg::RESULT_OFS:   rdata_next = {24'h000000, conversion_result_reg};
                adc_pkg::PORTCFG_OFS:  rdata_next = {24'h000000, port_analog_config_reg};
                adc_pkg::IRQ_STAT_OFS: rdata_next = {31'h00000000, irq_status_reg};
                adc_pkg::IRQ_EN_OFS:   rdata_next = {31'h00000000, irq_enable_reg};
                default:               rdata_next = 32'h00000000;
            endcase
        end
    end

    // Register all state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ack_reg                <= 1'b0;
            rdata_reg              <= 32'h00000000;
            converter_control_reg  <= adc_pkg::CONTROL_RST;
            conversion_result_reg  <= adc_pkg::RESULT_RST;
            port_analog_config_reg <= adc_pkg::PORTCFG_RST;
            irq_status_reg         <= adc_pkg::IRQ_RST;
            irq_enable_reg         <= adc_pkg::IRQ_RST;
            clk_sel_reg            <= adc_pkg::CLK_DIV2;
            tick_cnt_reg           <= 5'h00;
        end else begin
            ack_reg                <= ack_next;
            rdata_reg              <= rdata_next;
            converter_control_reg  <= converter_control_next;
            conversion_result_reg  <= conversion_result_next;
            port_analog_config_reg <= port_analog_config_next;
            irq_status_reg         <= irq_status_next;
            irq_enable_reg         <= irq_enable_next;
            clk_sel_reg            <= clk_sel_next;
            tick_cnt_reg           <= tick_cnt_next;
        end
    end

    // =====================================================================
    // Conversion clock and approximation register
    // =====================================================================
    // Divided sources count i_clk, so the bit period follows its rate
    conv_clock_gen #(
        .RC_HALF     (RC_HALF)
    ) u_clk (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_run       (go_reg),
        .i_sel       (clk_sel_reg),
        .o_half_tick (half_tick)
    );

    sar_register #(
        .WIDTH        (adc_pkg::RESULT_BITS)
    ) u_sar (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_start      (start),
        .i_step       (step),
        .i_comp_above (i_comp_above),
        .o_trial      (sar_code)
    );

    // =====================================================================
    // Analog front end and interrupt outputs
    // =====================================================================
    // Shared sample-and-hold holds for the whole conversion
    always_comb begin
        o_dac_code        = sar_code;
        o_mux_select      = converter_control_reg[adc_pkg::CHAN_LSB +: 2];
        o_mux_enable      = power_reg && converter_control_reg[adc_pkg::CHAN_LSB +: 3]
                         <= adc_pkg::CHAN_LAST;
        o_hold            = go_reg;
        o_ref_external    = port_analog_config_reg[adc_pkg::REFCFG_BIT];
        o_converter_power = power_reg;
        o_irq             = |(irq_status_reg & irq_enable_reg);
        o_wake            = o_irq && clk_sel_reg == adc_pkg::CLK_RC;
        o_avs_readdata    = rdata_reg;
    end

    // =====================================================================
    // Assertions
    // =====================================================================
    logic [8:0] busy_cnt_reg;
    logic [8:0] half_len;

    always_comb begin
        case (clk_sel_reg)
            adc_pkg::CLK_DIV2:  half_len = 9'(adc_pkg::HALF_DIV2);
            adc_pkg::CLK_DIV8:  half_len = 9'(adc_pkg::HALF_DIV8);
            adc_pkg::CLK_DIV32: half_len = 9'(adc_pkg::HALF_DIV32);
            default:            half_len = 9'(RC_HALF);
        endcase
    end

    // Cycles spent with go/done set
    always_ff @(posedge i_clk) begin
        if (i_rst || !go_reg) begin
            busy_cnt_reg <= 9'h000;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 9'h001;
        end
    end

    // Bit decisions taken since the last start; a full result needs one per bit
    logic [3:0] step_cnt_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst || start) begin
            step_cnt_reg <= 4'h0;
        end else if (step) begin
            step_cnt_reg <= step_cnt_reg + 4'h1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    conv_length_a: assert property (conv_done |->
        busy_cnt_reg == 9'(adc_pkg::CONV_HALVES) * half_len - 9'h001)
        else $error("conversion length wrong");
    result_write_a: assert property (conv_done |=>
        conversion_result_reg == $past(sar_code))
        else $error("result not stored");
    done_together_a: assert property (conv_done |=>
        !go_reg && irq_status_reg[0] && !$stable(go_reg))
        else $error("flag and go clear not together");
    start_go_a: assert property (start |=> go_reg && o_hold)
        else $error("start did not set go");
    disabled_go_a: assert property (!power_reg |-> !go_reg)
        else $error("go set while disabled");
    mux_legal_a: assert property (o_mux_enable |->
        converter_control_reg[5:3] <= 3'h3 && o_converter_power)
        else $error("reserved channel enabled");
    bits_count_a: assert property (conv_done |->
        step_cnt_reg == 4'(adc_pkg::RESULT_BITS))
        else $error("wrong number of bit decisions");
    irq_level_a: assert property ($rose(irq_status_reg[0]) && irq_enable_reg[0] |->
        o_irq)
        else $error("interrupt not raised");
    hold_busy_a: assert property (go_reg && !conv_done && !abort |=> o_hold)
        else $error("hold dropped mid conversion");

    conv_done_c: cover property (conv_done);
    rc_wake_c:   cover property (o_wake);
    abort_c:     cover property (abort);
    clr_race_c:  cover property (conv_done && wr_fire && i_avs_address == adc_pkg::IRQ_CLR_OFS);

endmodule

// >>> design/sar_register.sv
// Successive approximation register: trial code for the reference DAC.
// Assumes the comparator output is valid when a step strobe arrives.
`timescale 1ns/1ps
module sar_register #(
    parameter int WIDTH = adc_pkg::RESULT_BITS
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_start,
    input  wire logic             i_step,
    input  wire logic             i_comp_above,
    output logic [WIDTH-1:0]      o_trial
);

    // =====================================================================
    // Trial code and bit pointer
    // =====================================================================
    logic [WIDTH-1:0] trial_reg;
    logic [WIDTH-1:0] trial_next;
    logic [WIDTH-1:0] mask_reg;
    logic [WIDTH-1:0] mask_next;
    logic [WIDTH:0]   mask_ext;

    assign mask_ext = {1'b0, mask_reg};

    // Per bit: keep or drop the bit under test, then try the next lower one
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            always_comb begin
                if (i_start) begin
                    trial_next[b] = (b == WIDTH - 1);
                end else if (i_step && mask_reg[b]) begin
                    trial_next[b] = i_comp_above;
                end else if (i_step && mask_ext[b+1]) begin
                    trial_next[b] = 1'b1;
                end else begin
                    trial_next[b] = trial_reg[b];
                end
            end
        end
    endgenerate

    // Pointer walks one bit per step, from the top bit down
    always_comb begin
        if (i_start) begin
            mask_next = {1'b1, {(WIDTH-1){1'b0}}};
        end else if (i_step) begin
            mask_next = mask_reg >> 1;
        end else begin
            mask_next = mask_reg;
        end
    end

    // Register the state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            trial_reg <= '0;
            mask_reg  <= '0;
        end else begin
            trial_reg <= trial_next;
            mask_reg  <= mask_next;
        end
    end

    assign o_trial = trial_reg;

endmodule

// >>> verification/analog_front_model.sv
// Analog front end model: channel mux, sample-and-hold and comparator.
// Assumes the bench supplies four 8-bit input levels packed in one word.
`timescale 1ns/1ps
module analog_front_model (
    input  wire logic        i_clk,
    input  wire logic [31:0] i_levels,
    input  wire logic [1:0]  i_mux_select,
    input  wire logic        i_mux_enable,
    input  wire logic        i_hold,
    input  wire logic [7:0]  i_dac_code,
    output logic             o_comp_above
);
    logic [7:0] held_reg;
    // Track the selected input while sampling, freeze it while holding
    always @(posedge i_clk) begin
        if (!i_hold && i_mux_enable) begin
            held_reg <= i_levels[i_mux_select*8 +: 8];
        end
    end
    // Comparator: held level at or above the trial code
    assign o_comp_above = (held_reg >= i_dac_code);
endmodule

// >>> verification/sar_adc_control_bench.sv
// Self-checking bench of the converter control block over Avalon-MM.
// Assumes the front end model drives the comparator input.
`timescale 1ns/1ps
module sar_adc_control_bench;
    localparam int RCH = 2;
    logic        i_clk = 1'b0, i_rst = 1'b1, rd_s = 1'b0, wr_s = 1'b0, comp, hold_d = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [31:0] wdata = 32'h0, rdata, levels = 32'h015a00ff;
    logic [7:0]  dac;
    logic [1:0]  msel;
    logic        wreq, men, hold, refx, pwr, irq, wake;
    int          n_fail = 0, n_tests = 0, cyc = 0, hcnt = 0;
    int          halves[4] = '{adc_pkg::HALF_DIV2, adc_pkg::HALF_DIV8, adc_pkg::HALF_DIV32, RCH};
    sar_adc_control #(.RC_HALF(RCH)) u_sar_adc_control (.i_clk(i_clk), .i_rst(i_rst),
        .i_avs_address(addr), .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_comp_above(comp), .o_dac_code(dac), .o_mux_select(msel), .o_mux_enable(men),
        .o_hold(hold), .o_ref_external(refx), .o_converter_power(pwr), .o_irq(irq), .o_wake(wake));
    analog_front_model u_analog_front_model (.i_clk(i_clk), .i_levels(levels),
        .i_mux_select(msel), .i_mux_enable(men), .i_hold(hold), .i_dac_code(dac),
        .o_comp_above(comp));
    // =====================================================================
    // Clock, timeout and hold-length counter
    // =====================================================================
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        hold_d <= hold;
        hcnt <= (hold && !hold_d) ? 1 : (hold ? hcnt + 1 : hcnt);
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Bus cycles: hold the request until waitrequest is sampled low
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= {24'h0, d};
        wr_s <= 1'b1;
        do @(posedge i_clk); while (wreq !== 1'b0);
        wr_s <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] v);
        addr <= a;
        rd_s <= 1'b1;
        do @(posedge i_clk); while (wreq !== 1'b0);
        v = rdata;
        rd_s <= 1'b0;
        @(posedge i_clk);
    endtask
    // One conversion on a channel with a clock source, then result checks
    task automatic conv(input logic [1:0] sel, input logic [2:0] ch);
        logic [31:0] v;
        int n;
        wr(adc_pkg::CONTROL_OFS, {sel, ch, 3'b001});
        repeat (10) @(posedge i_clk); // Acquisition delay
        wr(adc_pkg::CONTROL_OFS, {sel, ch, 3'b101});
        rd(adc_pkg::CONTROL_OFS, v);
        chk("go busy", 32'h1, {31'h0, v[2]});
        n = 0;
        do begin
            rd(adc_pkg::CONTROL_OFS, v);
            n++;
        end while (v[2] !== 1'b0 && n < 500);
        chk("go done", 32'h0, {31'h0, v[2]});
        chk("hold cycles", adc_pkg::CONV_HALVES * halves[sel], hcnt);
        rd(adc_pkg::RESULT_OFS, v);
        chk("result", {24'h0, levels[ch*8 +: 8]}, v);
        rd(adc_pkg::IRQ_STAT_OFS, v);
        chk("status", 32'h1, v);
        chk("mux select", {30'h0, ch[1:0]}, {30'h0, msel});
    endtask
    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        logic [31:0] v;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        for (int k = 0; k < 4; k++) begin
            rd(5'(k * 4), v);
            chk("reset value", 32'h0, v);
        end
        rd(5'h18, v);
        chk("unmapped", 32'h0, v);
        wr(adc_pkg::PORTCFG_OFS, 8'h01); // Reference pin chosen before converting
        chk("ref external", 32'h1, {31'h0, refx});
        wr(adc_pkg::IRQ_EN_OFS, 8'h01);
        for (int s = 0; s < 4; s++) begin
            conv(2'(s), 3'(s));
            chk("irq", 32'h1, {31'h0, irq});
            chk("wake", {31'h0, s == 3}, {31'h0, wake});
            wr(adc_pkg::IRQ_CLR_OFS, 8'h01);
            chk("irq cleared", 32'h0, {31'h0, irq});
        end
        wr(adc_pkg::IRQ_EN_OFS, 8'h00);
        conv(2'h0, 3'h2);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(adc_pkg::CONTROL_OFS, 8'h2d);
        chk("reserved mux", 32'h0, {31'h0, men});
        wr(adc_pkg::CONTROL_OFS, 8'h28); // Power off aborts the busy conversion
        chk("abort hold", 32'h0, {31'h0, hold});
        rd(adc_pkg::CONTROL_OFS, v);
        chk("abort control", 32'h28, v);
        wr(adc_pkg::CONTROL_OFS, 8'h04);
        rd(adc_pkg::CONTROL_OFS, v);
        chk("go while off", 32'h0, v);
        chk("power", 32'h0, {31'h0, pwr});
        test_done();
    end
endmodule
